/* include/cfg_status_pkg.sv */
// Package for the configuration status and trace buffer control registers.
// Assumes a 32-bit register port with word-aligned byte addresses.
package cfg_status_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [31:0] DEV_CFG_STATUS_ADDR   = 32'h02A80000;
  localparam logic [31:0] TRACE_BUF_PWR_ADDR    = 32'h02AC0054;
  localparam logic [31:0] UNMAPPED_READ_VALUE   = 32'h00000000;

  // ==========================================================================
  // Field positions of the configuration status and trace buffer control registers
  // ==========================================================================
  localparam int EXT_MEM_ON_BIT   = 22;
  localparam int DRAM_ON_BIT      = 21;
  localparam int PCI_SEL_BIT      = 20;
  localparam int GP_CFG_LSB       = 17;
  localparam int GP_CFG_W         = 3;
  localparam int RSVD16_BIT       = 16;
  localparam int CLKOUT_EN_BIT    = 15;
  localparam int SERIAL1_EN_BIT   = 14;
  localparam int PCI66_BIT        = 13;
  localparam int PCI_EEAI_BIT     = 11;
  localparam int ETH_SEL_LSB      = 9;
  localparam int ETH_SEL_W        = 2;
  localparam int RSVD8_BIT        = 8;
  localparam int ENDIAN_BIT       = 6;
  localparam int HOST_WIDTH_BIT   = 5;
  localparam int MEM_CLK_SEL_BIT  = 4;
  localparam int BOOT_LSB         = 0;
  localparam int BOOT_W           = 4;
  localparam int TRACE_PD_BIT     = 0;

  // ==========================================================================
  // Encodings and reset values
  // ==========================================================================
  localparam logic [1:0] ETH_MII   = 2'h0;
  localparam logic [1:0] ETH_RMII  = 2'h1;
  localparam logic [1:0] ETH_GMII  = 2'h2;
  localparam logic [1:0] ETH_RGMII = 2'h3;
  localparam logic [3:0] BOOT_NONE = 4'h0;
  localparam logic       TRACE_PD_RESET = 1'h0;

  // Values that the internal pulls give when nothing drives the straps.
  localparam logic [31:0] DEV_CFG_STATUS_DEFAULT = 32'h00010140;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic        ext_mem_if_pins_on;
    logic        dram_ctrl_pins_on;
    logic        pci_pins_on;
    logic [2:0]  gp_config_inputs;
    logic        clkout_on;
    logic        serial1_pins_on;
    logic        pci_66mhz;
    logic        pci_eeprom_init;
    logic        eth_if_select_hi;
    logic        eth_if_select_lo;
    logic        little_endian_flag;
    logic        host_port_32bit;
    logic        mem_clk_select;
    logic [3:0]  boot_select;
  } strap_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    ST_IN_RESET = 3'h1,
    ST_CAPTURE  = 3'h2,
    ST_HOLD     = 3'h4
  } cap_state_t;

endpackage

/* hdl/strap_sync.sv */
// Two-flip-flop synchroniser for a vector of strap pins.
// Assumes the pins are static around reset release and only need a clean sample.
`timescale 1ns/10ps
module strap_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q   <= '0;
      pin_sync <= '0;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end

endmodule

/* hdl/device_config_status_regs.sv */
// Configuration status register captured from straps at reset release, and
// the trace pin buffer power-down control bit, on a simple register port.
// Assumes strap pins are stable while srst is high and for a few cycles after.
//
// Local design decision: strobed register access.
`timescale 1ns/10ps

// Behaviour
// R1: Bit 0 set powers trace buffers down.
// R2: Status captured at reset exit, held.
// R3: Peripheral config writes leave status untouched.
// R4: Fields sampled from straps at reset.
// R5: Bit 22 reports external memory pins.
// R6: Bit 21 reports DRAM controller pins.
// R7: Bit 20: 0 host port, 1 PCI.
// R8: Bits 19:17 hold general-purpose strap inputs.
// R9: Status reserved bits read-only, writes ignored.
// R10: Software powers down only without trace.
// R11: Ethernet select encodes MII/RMII/GMII/RGMII.
// R12: Endian bit 1 means little endian.
// R13: Low four bits report boot mode.
// R14: Control reserved bits read zero.
module device_config_status_regs
  import cfg_status_pkg::*;
#(
  parameter int SETTLE_CYCLES = 2
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Configuration strap pins
  input  wire strap_t      strap_pins,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Trace pin buffer control
  output logic             trace_buf_powerdown
);

  // ==========================================================================
  // Strap synchronisation
  // ==========================================================================
  strap_t     strap_sync_s;
  reg_req_t   req;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  strap_sync #(
    .WIDTH ($bits(strap_t))
  ) u_strap_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .pin_in   (strap_pins),
    .pin_sync (strap_sync_s)
  );

  // ==========================================================================
  // Capture sequencer
  // ==========================================================================
  // With SETTLE_CYCLES from 1 to 15 the capture waits for the synchroniser to refill
  // after reset, so the register never latches the flops' cleared contents.
  cap_state_t state_q;
  cap_state_t state_d;
  logic [3:0] settle_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IN_RESET: begin
        if (settle_q == 4'(SETTLE_CYCLES)) begin
          state_d = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        state_d = ST_HOLD;
      end
      ST_HOLD: begin
        state_d = ST_HOLD;
      end
      default: begin
        state_d = ST_IN_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IN_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      settle_q <= 4'h0;
    end else if (state_q == ST_IN_RESET) begin
      settle_q <= settle_q + 4'h1;
    end
  end

  // ==========================================================================
  // Configuration status fields
  // ==========================================================================
  // Each field keeps its pull-resistor default until the one capture strobe,
  // and no bus write reaches any of them.
  logic                 capture_en;
  logic                 ext_mem_on_q;
  logic                 ext_mem_on_d;
  logic                 dram_on_q;
  logic                 dram_on_d;
  logic                 pci_sel_q;
  logic                 pci_sel_d;
  logic [GP_CFG_W-1:0]  gp_cfg_q;
  logic [GP_CFG_W-1:0]  gp_cfg_d;
  logic                 clkout_on_q;
  logic                 clkout_on_d;
  logic                 serial1_on_q;
  logic                 serial1_on_d;
  logic                 pci66_q;
  logic                 pci66_d;
  logic                 pci_eeprom_q;
  logic                 pci_eeprom_d;
  logic [ETH_SEL_W-1:0] eth_sel_q;
  logic [ETH_SEL_W-1:0] eth_sel_d;
  logic                 little_endian_q;
  logic                 little_endian_d;
  logic                 host_width_q;
  logic                 host_width_d;
  logic                 mem_clk_sel_q;
  logic                 mem_clk_sel_d;
  logic [BOOT_W-1:0]    boot_sel_q;
  logic [BOOT_W-1:0]    boot_sel_d;
  logic [31:0]          cfg_status_word;

  assign capture_en = (state_q == ST_CAPTURE);

  always_comb begin
    ext_mem_on_d    = ext_mem_on_q;
    dram_on_d       = dram_on_q;
    pci_sel_d       = pci_sel_q;
    gp_cfg_d        = gp_cfg_q;
    clkout_on_d     = clkout_on_q;
    serial1_on_d    = serial1_on_q;
    pci66_d         = pci66_q;
    pci_eeprom_d    = pci_eeprom_q;
    eth_sel_d       = eth_sel_q;
    little_endian_d = little_endian_q;
    host_width_d    = host_width_q;
    mem_clk_sel_d   = mem_clk_sel_q;
    boot_sel_d      = boot_sel_q;
    if (capture_en) begin // R2 R3 R9
      ext_mem_on_d    = strap_sync_s.ext_mem_if_pins_on; // R5
      dram_on_d       = strap_sync_s.dram_ctrl_pins_on; // R6
      pci_sel_d       = strap_sync_s.pci_pins_on; // R7
      gp_cfg_d        = strap_sync_s.gp_config_inputs; // R8
      clkout_on_d     = strap_sync_s.clkout_on;
      serial1_on_d    = strap_sync_s.serial1_pins_on;
      pci66_d         = strap_sync_s.pci_66mhz;
      pci_eeprom_d    = strap_sync_s.pci_eeprom_init;
      eth_sel_d       = {strap_sync_s.eth_if_select_hi, strap_sync_s.eth_if_select_lo}; // R11
      little_endian_d = strap_sync_s.little_endian_flag; // R12
      host_width_d    = strap_sync_s.host_port_32bit;
      mem_clk_sel_d   = strap_sync_s.mem_clk_select;
      boot_sel_d      = strap_sync_s.boot_select; // R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_mem_on_q <= DEV_CFG_STATUS_DEFAULT[EXT_MEM_ON_BIT]; // R4
    end else begin
      ext_mem_on_q <= ext_mem_on_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dram_on_q <= DEV_CFG_STATUS_DEFAULT[DRAM_ON_BIT]; // R4
    end else begin
      dram_on_q <= dram_on_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pci_sel_q <= DEV_CFG_STATUS_DEFAULT[PCI_SEL_BIT]; // R4
    end else begin
      pci_sel_q <= pci_sel_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      gp_cfg_q <= DEV_CFG_STATUS_DEFAULT[GP_CFG_LSB +: GP_CFG_W]; // R4
    end else begin
      gp_cfg_q <= gp_cfg_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      clkout_on_q <= DEV_CFG_STATUS_DEFAULT[CLKOUT_EN_BIT]; // R4
    end else begin
      clkout_on_q <= clkout_on_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      serial1_on_q <= DEV_CFG_STATUS_DEFAULT[SERIAL1_EN_BIT]; // R4
    end else begin
      serial1_on_q <= serial1_on_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pci66_q <= DEV_CFG_STATUS_DEFAULT[PCI66_BIT]; // R4
    end else begin
      pci66_q <= pci66_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pci_eeprom_q <= DEV_CFG_STATUS_DEFAULT[PCI_EEAI_BIT]; // R4
    end else begin
      pci_eeprom_q <= pci_eeprom_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      eth_sel_q <= DEV_CFG_STATUS_DEFAULT[ETH_SEL_LSB +: ETH_SEL_W]; // R4
    end else begin
      eth_sel_q <= eth_sel_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      little_endian_q <= DEV_CFG_STATUS_DEFAULT[ENDIAN_BIT]; // R4
    end else begin
      little_endian_q <= little_endian_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      host_width_q <= DEV_CFG_STATUS_DEFAULT[HOST_WIDTH_BIT]; // R4
    end else begin
      host_width_q <= host_width_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_clk_sel_q <= DEV_CFG_STATUS_DEFAULT[MEM_CLK_SEL_BIT]; // R4
    end else begin
      mem_clk_sel_q <= mem_clk_sel_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      boot_sel_q <= DEV_CFG_STATUS_DEFAULT[BOOT_LSB +: BOOT_W]; // R4
    end else begin
      boot_sel_q <= boot_sel_d;
    end
  end

  // Reserved bits take their fixed levels, so a write can never move them.
  always_comb begin
    cfg_status_word                         = 32'h00000000;
    cfg_status_word[RSVD16_BIT]             = DEV_CFG_STATUS_DEFAULT[RSVD16_BIT]; // R9
    cfg_status_word[RSVD8_BIT]              = DEV_CFG_STATUS_DEFAULT[RSVD8_BIT];
    cfg_status_word[EXT_MEM_ON_BIT]         = ext_mem_on_q; // R5
    cfg_status_word[DRAM_ON_BIT]            = dram_on_q; // R6
    cfg_status_word[PCI_SEL_BIT]            = pci_sel_q; // R7
    cfg_status_word[GP_CFG_LSB +: GP_CFG_W] = gp_cfg_q; // R8
    cfg_status_word[CLKOUT_EN_BIT]          = clkout_on_q;
    cfg_status_word[SERIAL1_EN_BIT]         = serial1_on_q;
    cfg_status_word[PCI66_BIT]              = pci66_q;
    cfg_status_word[PCI_EEAI_BIT]           = pci_eeprom_q;
    cfg_status_word[ETH_SEL_LSB +: ETH_SEL_W] = eth_sel_q; // R11
    cfg_status_word[ENDIAN_BIT]             = little_endian_q; // R12
    cfg_status_word[HOST_WIDTH_BIT]         = host_width_q;
    cfg_status_word[MEM_CLK_SEL_BIT]        = mem_clk_sel_q;
    cfg_status_word[BOOT_LSB +: BOOT_W]     = boot_sel_q; // R13
  end

  // ==========================================================================
  // Trace buffer power-down control
  // ==========================================================================
  logic trace_pd_d;

  always_comb begin
    trace_pd_d = trace_buf_powerdown;
    if (req.wr && req.addr == TRACE_BUF_PWR_ADDR) begin
      trace_pd_d = req.wdata[TRACE_PD_BIT]; // R1 R14
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      trace_buf_powerdown <= TRACE_PD_RESET;
    end else begin
      trace_buf_powerdown <= trace_pd_d;
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  // The answer stands for one cycle only; an idle port reads zero.
  logic        hit_status;
  logic        hit_trace;
  logic [31:0] rdata_d;

  always_comb begin
    hit_status = (req.addr == DEV_CFG_STATUS_ADDR);
    hit_trace  = (req.addr == TRACE_BUF_PWR_ADDR);
    rdata_d    = 32'h00000000;
    if (req.rd) begin
      if (hit_status) begin
        rdata_d = cfg_status_word; // R2 R3 R9
      end else if (hit_trace) begin
        rdata_d = {31'h00000000, trace_buf_powerdown}; // R14
      end else begin
        rdata_d = UNMAPPED_READ_VALUE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

/* testbench/cfg_regs_props.sv */
// Assertions on the configuration status and trace control register port.
// Assumes it is bound to the register bank top and sees only its ports.
`timescale 1ns/10ps
module cfg_regs_props
  import cfg_status_pkg::*;
#(
  parameter int SETTLE_CYCLES = 2
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // Straps and register port
  input wire strap_t      strap_pins,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        trace_buf_powerdown
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [4:0]  up_q;
  logic        stat_q;
  logic        have_q;
  logic [31:0] last_q;
  sequence trace_wr;
    reg_wr && reg_addr == TRACE_BUF_PWR_ADDR;
  endsequence
  sequence stat_rd;
    reg_rd && reg_addr == DEV_CFG_STATUS_ADDR;
  endsequence
  // Remembers the latest settled status read after each reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      up_q <= 5'h00;
      stat_q <= 1'b0;
      have_q <= 1'b0;
    end else begin
      up_q <= (up_q == 5'h1F) ? up_q : up_q + 5'h01;
      stat_q <= reg_rd && reg_addr == DEV_CFG_STATUS_ADDR && up_q > SETTLE_CYCLES + 3;
      if (stat_q) begin
        have_q <= 1'b1;
        last_q <= reg_rdata;
      end
    end
  end
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data not zero when idle");
  pd_set_a: assert property (trace_wr and reg_wdata[0] |=> trace_buf_powerdown) else $error("powerdown not set");
  pd_clear_a: assert property (trace_wr and !reg_wdata[0] |=> !trace_buf_powerdown) else $error("powerdown not clear");
  pd_hold_a: assert property (!reg_wr |=> $stable(trace_buf_powerdown)) else $error("powerdown moved");
  pd_reset_a: assert property ($fell(srst) |-> !trace_buf_powerdown && reg_rdata == 32'h0) else $error("bad reset");
  pd_read_a: assert property (reg_rd && reg_addr == TRACE_BUF_PWR_ADDR |=>
    reg_rdata == {31'h0, $past(trace_buf_powerdown)}) else $error("trace read wrong");
  stat_rsvd_a: assert property (stat_rd |=> reg_rdata[31:23] == 9'h0 && reg_rdata[16] && !reg_rdata[12] &&
    reg_rdata[8:7] == 2'h2) else $error("status reserved bits wrong");
  stat_hold_a: assert property (stat_q && have_q |-> reg_rdata == last_q) else $error("status changed");
  unmapped_rd_a: assert property (reg_rd && reg_addr != TRACE_BUF_PWR_ADDR && reg_addr != DEV_CFG_STATUS_ADDR |=>
    reg_rdata == UNMAPPED_READ_VALUE) else $error("unmapped read not zero");
endmodule

/* testbench/device_config_status_regs_tb.sv */
// Self-checking bench for the status and trace control registers.
// Assumes the register port answers a read one cycle later.
`timescale 1ns/10ps
module device_config_status_regs_tb;
  import cfg_status_pkg::*;
  localparam int SETTLE = 3;
  logic        core_clk  = 1'b0;
  logic        srst      = 1'b1;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        rd_seen   = 1'b0;
  logic [31:0] reg_addr  = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        trace_buf_powerdown;
  strap_t      strap_pins = '0;
  logic [15:0] lfsr_q = 16'h386F;
  logic [31:0] exp_q[$];
  int          n_errors = 0;
  int          samples_checked = 0;
  device_config_status_regs #(.SETTLE_CYCLES(SETTLE)) dut (.core_clk(core_clk), .srst(srst),
    .strap_pins(strap_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trace_buf_powerdown(trace_buf_powerdown));
  initial forever #2 core_clk = ~core_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] stat_of(input strap_t s);
    return {9'h0, s.ext_mem_if_pins_on, s.dram_ctrl_pins_on, s.pci_pins_on, s.gp_config_inputs, 1'b1,
      s.clkout_on, s.serial1_pins_on, s.pci_66mhz, 1'b0, s.pci_eeprom_init, s.eth_if_select_hi,
      s.eth_if_select_lo, 2'h2, s.little_endian_flag, s.host_port_32bit, s.mem_clk_select, s.boot_select};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic op(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 32'h0);
  endtask
  task automatic boot(input strap_t s);
    srst <= 1'b1;
    strap_pins <= s;
    op(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (7) @(posedge core_clk);
    srst <= 1'b0;
    rd(DEV_CFG_STATUS_ADDR, DEV_CFG_STATUS_DEFAULT);
    op(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (SETTLE + 2) @(posedge core_clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Compares each read answer with the oldest queued expectation.
  always @(posedge core_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk("queue", 32'h1, 32'h0);
      else chk("rdata", exp_q.pop_front(), reg_rdata);
    end
    rd_seen <= reg_rd;
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    chk("watchdog", 32'h0, 32'h1);
    tally_and_finish();
  end
  initial begin
    strap_t s;
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      s = {lfsr_q, lfsr_q[4:0]};
      {s.eth_if_select_hi, s.eth_if_select_lo} = i[1:0];
      if (i == 0) s.boot_select = BOOT_NONE;
      boot(s);
      rd(DEV_CFG_STATUS_ADDR, stat_of(s));
      strap_pins <= ~s;
      op(1'b1, 1'b0, DEV_CFG_STATUS_ADDR, 32'hFFFFFFFF);
      op(1'b1, 1'b0, 32'h02AC0000, 32'hFFFFFFFF);
      rd(DEV_CFG_STATUS_ADDR, stat_of(s));
      op(1'b0, 1'b0, 32'h0, 32'h0);
      $display("strap test %0d done", i);
    end
    op(1'b1, 1'b0, TRACE_BUF_PWR_ADDR, 32'h1);
    rd(TRACE_BUF_PWR_ADDR, 32'h1);
    chk("powerdown", 32'h1, {31'h0, trace_buf_powerdown});
    op(1'b1, 1'b0, TRACE_BUF_PWR_ADDR, 32'hFFFFFFFE);
    rd(TRACE_BUF_PWR_ADDR, 32'h0);
    chk("powerdown", 32'h0, {31'h0, trace_buf_powerdown});
    op(1'b1, 1'b0, TRACE_BUF_PWR_ADDR, 32'hFFFFFFFF);
    rd(TRACE_BUF_PWR_ADDR, 32'h1);
    rd(32'h02AC0058, UNMAPPED_READ_VALUE);
    lfsr_q = lfsr(lfsr_q);
    op(1'b1, 1'b0, TRACE_BUF_PWR_ADDR, {lfsr_q, lfsr_q});
    rd(TRACE_BUF_PWR_ADDR, {31'h0, lfsr_q[0]});
    boot(s);
    chk("powerdown", 32'h0, {31'h0, trace_buf_powerdown});
    rd(TRACE_BUF_PWR_ADDR, 32'h0);
    op(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (2) @(posedge core_clk);
    $display("trace test done");
    tally_and_finish();
  end
endmodule
bind device_config_status_regs cfg_regs_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) props (.core_clk(core_clk),
  .srst(srst), .strap_pins(strap_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trace_buf_powerdown(trace_buf_powerdown));
